// [hdl/ilk_pkg.sv]
// Package for the interlock diagnostic controller: register map, flash codes, timing.
// Assumes a 20 MHz single clock domain and a classic Wishbone register slave.
package ilk_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 20000000;           // System clock rate
  localparam int unsigned SHUTDOWN_DELAY_MIN = 30;     // Warning to failure delay, minutes
  localparam int unsigned YEL_FLASH_HZ = 3;            // Yellow flash rate
  localparam int unsigned RED_PULSE_MS = 200;          // Red pulse on and off time
  localparam int unsigned RED_PAUSE_MS = 1200;         // Dark gap between code groups
  localparam int unsigned TICK_MS = 1;                 // Base tick period
  localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
  localparam int unsigned YEL_HALF_TICKS = 1000 / (YEL_FLASH_HZ * 2) / TICK_MS;
  localparam int unsigned RED_PULSE_TICKS = RED_PULSE_MS / TICK_MS;
  localparam int unsigned RED_PAUSE_TICKS = RED_PAUSE_MS / TICK_MS;
  localparam int unsigned SHUTDOWN_TICKS = SHUTDOWN_DELAY_MIN * 60 * 1000 / TICK_MS;

  // ----------------------------------------------------------------
  // Flash codes (pulse count per group)
  // ----------------------------------------------------------------
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_OUT_A = 3'h1;
  localparam logic [2:0] CODE_OUT_B = 3'h2;
  localparam logic [2:0] CODE_CROSS = 3'h3;
  localparam logic [2:0] CODE_TEMP = 3'h4;
  localparam logic [2:0] CODE_ACT = 3'h5;
  localparam logic [2:0] CODE_COMBO = 3'h6;
  localparam logic [2:0] CODE_INTERNAL = 3'h7;         // Shown as steady red

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;             // Control
  localparam logic [3:0] ADDR_STATUS = 4'h4;           // Status, read only
  localparam logic [3:0] ADDR_OUTS = 4'h8;             // Output levels, read only
  localparam logic [3:0] ADDR_TIMER = 4'hC;            // Warning timer, read only
  localparam int unsigned CTRL_BIT_ENABLE = 0;         // Device ready
  localparam int unsigned CTRL_BIT_LOCK = 1;           // Solenoid lock command
  localparam logic [1:0] CTRL_RESET = 2'h1;

  // Red flash sequencer states
  typedef enum logic [2:0] {
    RED_DARK = 3'b001,
    RED_ON = 3'b010,
    RED_OFF = 3'b100
  } ilk_red_t;

endpackage : ilk_pkg

// [hdl/ilk_diag.sv]
// Interlock diagnostic controller: safety outputs, diagnostic output, LEDs, warning timer.
// Sensor and self-test inputs arrive asynchronously and are synchronised here.
//
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
module ilk_diag
  import ilk_pkg::*;
#(
  parameter int unsigned SHUTDOWN_TICKS_P = SHUTDOWN_TICKS,   // Warning delay in ticks
  parameter int unsigned TICK_CYC_P = TICK_CYC                 // Clocks per tick
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Sensing inputs (asynchronous)
  input wire logic guard_closed_i,
  input wire logic actuator_in_i,
  input wire logic actuator_marginal_i,
  input wire logic lock_target_i,
  // Fault detectors (asynchronous levels)
  input wire logic fault_out_a_i,
  input wire logic fault_out_b_i,
  input wire logic fault_cross_i,
  input wire logic fault_temp_i,
  input wire logic fault_actuator_i,
  input wire logic fault_combo_i,
  input wire logic fault_internal_i,
  // Safety and diagnostic outputs
  output logic guard_safety_out_a_o,
  output logic guard_safety_out_b_o,
  output logic lock_safety_out_a_o,
  output logic lock_safety_out_b_o,
  output logic diag_out_o,
  // Indicators
  output logic led_green_o,
  output logic led_yellow_o,
  output logic led_red_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  localparam int unsigned NSYNC = 11;
  logic [NSYNC-1:0] raw_in;
  logic [NSYNC-1:0] sync1_reg;   // First stage, read only by second stage
  logic [NSYNC-1:0] sync2_reg;   // Stable copy used by all logic
  assign raw_in = {fault_internal_i, fault_combo_i, fault_actuator_i, fault_temp_i,
                   fault_cross_i, fault_out_b_i, fault_out_a_i, lock_target_i,
                   actuator_marginal_i, actuator_in_i, guard_closed_i};

  // Two flops per bit; pins are asynchronous to clk_i
  genvar gi;
  generate
    for (gi = 0; gi < NSYNC; gi++) begin : g_sync
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          sync1_reg[gi] <= 1'b0;
          sync2_reg[gi] <= 1'b0;
        end else begin
          sync1_reg[gi] <= raw_in[gi];
          sync2_reg[gi] <= sync1_reg[gi];
        end
      end
    end
  endgenerate

  logic guard_closed, act_in, act_marginal, lock_tgt;
  logic f_out_a, f_out_b, f_cross, f_temp, f_act, f_combo, f_int;
  assign {f_int, f_combo, f_act, f_temp, f_cross, f_out_b, f_out_a, lock_tgt,
          act_marginal, act_in, guard_closed} = sync2_reg;

  // ----------------------------------------------------------------
  // Tick divider (1 ms enable)
  // ----------------------------------------------------------------
  logic [31:0] div_reg, div_next;
  logic tick;
  assign tick = (div_reg == 32'(TICK_CYC_P - 1));

  // Next divider value
  always_comb begin
    div_next = tick ? 32'h0 : div_reg + 32'h1;
  end

  // Divider register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 32'h0;
    end else begin
      div_reg <= div_next;
    end
  end

  // ----------------------------------------------------------------
  // Control register
  // ----------------------------------------------------------------
  logic [1:0] ctrl_reg, ctrl_next;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic wb_req;
  assign wb_req = wb_cyc_i && wb_stb_i && !ack_reg;   // Drop ack one cycle after giving it

  logic ready;
  logic lock_cmd;
  assign ready = ctrl_reg[CTRL_BIT_ENABLE];
  assign lock_cmd = ctrl_reg[CTRL_BIT_LOCK];

  // ----------------------------------------------------------------
  // Fault classification
  // ----------------------------------------------------------------
  // Priority: internal, then combination, actuator, then warning classes
  logic warn_any, imm_any;
  logic [2:0] warn_code, imm_code;
  assign imm_any = f_int || f_combo || f_act;
  assign warn_any = f_out_a || f_out_b || f_cross || f_temp;

  // Immediate fault code
  always_comb begin
    if (f_int) begin
      imm_code = CODE_INTERNAL;
    end else if (f_combo) begin
      imm_code = CODE_COMBO;
    end else if (f_act) begin
      imm_code = CODE_ACT;
    end else begin
      imm_code = CODE_NONE;
    end
  end

  // Warning code; both outputs faulty counts as cross-wire
  always_comb begin
    if (f_cross || (f_out_a && f_out_b)) begin
      warn_code = CODE_CROSS;
    end else if (f_temp) begin
      warn_code = CODE_TEMP;
    end else if (f_out_a) begin
      warn_code = CODE_OUT_A;
    end else if (f_out_b) begin
      warn_code = CODE_OUT_B;
    end else begin
      warn_code = CODE_NONE;
    end
  end

  // ----------------------------------------------------------------
  // Warning timer and latched failure
  // ----------------------------------------------------------------
  logic [31:0] wtim_reg, wtim_next;
  logic fail_reg, fail_next;            // Latched failure
  logic [2:0] fcode_reg, fcode_next;    // Code captured at failure
  logic seen_open_reg, seen_open_next;  // Guard opened since cause removed

  // Warning runs the timer; expiry or an immediate fault latches a failure
  always_comb begin
    wtim_next = wtim_reg;
    fail_next = fail_reg;
    fcode_next = fcode_reg;
    seen_open_next = seen_open_reg;
    if (warn_any && !fail_reg) begin
      if (tick && wtim_reg < SHUTDOWN_TICKS_P) begin
        wtim_next = wtim_reg + 32'h1;
      end
    end else if (!warn_any) begin
      wtim_next = 32'h0;
    end
    if (imm_any) begin
      fail_next = 1'b1;
      fcode_next = imm_code;
      seen_open_next = 1'b0;
    end else if (warn_any && wtim_reg >= SHUTDOWN_TICKS_P) begin
      fail_next = 1'b1;
      if (!fail_reg) begin
        fcode_next = warn_code;
      end
      seen_open_next = 1'b0;
    end else if (fail_reg) begin
      // Cause gone: wait for open then close of the guard
      if (!guard_closed) begin
        seen_open_next = 1'b1;
      end else if (seen_open_reg) begin
        fail_next = 1'b0;
        seen_open_next = 1'b0;
        fcode_next = CODE_NONE;
      end
    end
  end

  // Failure state registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wtim_reg <= 32'h0;
      fail_reg <= 1'b0;
      fcode_reg <= CODE_NONE;
      seen_open_reg <= 1'b0;
    end else begin
      wtim_reg <= wtim_next;
      fail_reg <= fail_next;
      fcode_reg <= fcode_next;
      seen_open_reg <= seen_open_next;
    end
  end

  // ----------------------------------------------------------------
  // Output decision
  // ----------------------------------------------------------------
  logic warning;
  logic locked;
  logic [2:0] shown_code;
  assign warning = warn_any && !fail_reg;
  assign locked = act_in && lock_tgt && lock_cmd;
  assign shown_code = fail_reg ? fcode_reg : (warning ? warn_code : CODE_NONE);

  logic ga_next, gb_next, la_next, lb_next, dg_next;
  logic ga_reg, gb_reg, la_reg, lb_reg, dg_reg;
  logic yel_mode_next, yel_flash_next;   // Yellow on, and flashing
  logic yel_mode_reg, yel_flash_reg;

  // Output levels per system condition
  always_comb begin
    ga_next = 1'b0;
    gb_next = 1'b0;
    la_next = 1'b0;
    lb_next = 1'b1;
    dg_next = 1'b0;
    yel_mode_next = 1'b0;
    yel_flash_next = 1'b0;
    if (!ready) begin
      // Not ready: everything safe
    end else if (fail_reg) begin
      la_next = 1'b1;
      lb_next = 1'b0;
    end else if (!guard_closed) begin
      // Guard open: defaults hold
    end else if (!act_in) begin
      ga_next = 1'b1;
      gb_next = 1'b1;
      yel_mode_next = 1'b1;
      yel_flash_next = 1'b1;
    end else if (!locked) begin
      ga_next = 1'b1;
      gb_next = 1'b1;
      dg_next = !warning;
      yel_mode_next = 1'b1;
      yel_flash_next = 1'b1;
    end else begin
      ga_next = 1'b1;
      gb_next = 1'b1;
      la_next = 1'b1;
      lb_next = 1'b0;
      dg_next = !warning;
      yel_mode_next = 1'b1;
      yel_flash_next = act_marginal;
    end
  end

  // Output registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ga_reg <= 1'b0;
      gb_reg <= 1'b0;
      la_reg <= 1'b0;
      lb_reg <= 1'b1;
      dg_reg <= 1'b0;
      yel_mode_reg <= 1'b0;
      yel_flash_reg <= 1'b0;
    end else begin
      ga_reg <= ga_next;
      gb_reg <= gb_next;
      la_reg <= la_next;
      lb_reg <= lb_next;
      dg_reg <= dg_next;
      yel_mode_reg <= yel_mode_next;
      yel_flash_reg <= yel_flash_next;
    end
  end

  // ----------------------------------------------------------------
  // Yellow flasher (3 Hz)
  // ----------------------------------------------------------------
  logic [15:0] ycnt_reg, ycnt_next;
  logic yph_reg, yph_next;

  // Half-period counter toggles the phase
  always_comb begin
    ycnt_next = ycnt_reg;
    yph_next = yph_reg;
    if (tick) begin
      if (ycnt_reg == 16'(YEL_HALF_TICKS - 1)) begin
        ycnt_next = 16'h0;
        yph_next = !yph_reg;
      end else begin
        ycnt_next = ycnt_reg + 16'h1;
      end
    end
  end

  // Yellow phase registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ycnt_reg <= 16'h0;
      yph_reg <= 1'b0;
    end else begin
      ycnt_reg <= ycnt_next;
      yph_reg <= yph_next;
    end
  end

  // ----------------------------------------------------------------
  // Red flash-code sequencer
  // ----------------------------------------------------------------
  ilk_red_t rst_state_reg, rst_state_next;
  logic [15:0] rcnt_reg, rcnt_next;
  logic [2:0] rpul_reg, rpul_next;     // Pulses left in group
  logic [2:0] rcode;
  assign rcode = shown_code;

  // Pulse group then long pause; code latched at group start
  always_comb begin
    rst_state_next = rst_state_reg;
    rcnt_next = rcnt_reg;
    rpul_next = rpul_reg;
    if (tick) begin
      rcnt_next = rcnt_reg + 16'h1;
      case (rst_state_reg)
        RED_DARK: begin
          if (rcnt_reg >= 16'(RED_PAUSE_TICKS - 1)) begin
            rcnt_next = 16'h0;
            if (rcode != CODE_NONE && rcode != CODE_INTERNAL) begin
              rst_state_next = RED_ON;
              rpul_next = rcode;
            end
          end
        end
        RED_ON: begin
          if (rcnt_reg >= 16'(RED_PULSE_TICKS - 1)) begin
            rcnt_next = 16'h0;
            rpul_next = rpul_reg - 3'h1;
            rst_state_next = RED_OFF;
          end
        end
        RED_OFF: begin
          if (rcnt_reg >= 16'(RED_PULSE_TICKS - 1)) begin
            rcnt_next = 16'h0;
            rst_state_next = (rpul_reg == 3'h0) ? RED_DARK : RED_ON;
          end
        end
        default: begin
          rst_state_next = RED_DARK;
          rcnt_next = 16'h0;
        end
      endcase
    end
    // Nothing to show: drop any group, so a later fault starts a full one
    if (rcode == CODE_NONE) begin
      rst_state_next = RED_DARK;
    end
  end

  // Red sequencer registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rst_state_reg <= RED_DARK;
      rcnt_reg <= 16'h0;
      rpul_reg <= 3'h0;
    end else begin
      rst_state_reg <= rst_state_next;
      rcnt_reg <= rcnt_next;
      rpul_reg <= rpul_next;
    end
  end

  // ----------------------------------------------------------------
  // Wishbone slave: single-cycle registered ack
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_next = ctrl_reg;
    ack_next = wb_req;
    rdat_next = rdat_reg;
    if (wb_req) begin
      rdat_next = 32'h0;                                 // Unmapped reads as zero
      if (wb_we_i) begin
        if (wb_adr_i == ADDR_CTRL && wb_sel_i[0]) begin
          ctrl_next = wb_dat_i[1:0];
        end
      end else begin
        case (wb_adr_i)
          ADDR_CTRL: rdat_next = {30'h0, ctrl_reg};
          ADDR_STATUS: rdat_next = {20'h0, shown_code, fail_reg, warning,
                                    f_int, f_combo, f_act, f_temp, f_cross, f_out_b, f_out_a};
          ADDR_OUTS: rdat_next = {24'h0, yel_mode_reg, led_red_o, dg_reg, lb_reg, la_reg,
                                  gb_reg, ga_reg, ready};
          ADDR_TIMER: rdat_next = wtim_reg;
          default: rdat_next = 32'h0;
        endcase
      end
    end
  end

  // Bus registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= CTRL_RESET;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h0;
    end else begin
      ctrl_reg <= ctrl_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  // ----------------------------------------------------------------
  // Output assignments
  // ----------------------------------------------------------------
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign guard_safety_out_a_o = ga_reg;
  assign guard_safety_out_b_o = gb_reg;
  assign lock_safety_out_a_o = la_reg;
  assign lock_safety_out_b_o = lb_reg;
  assign diag_out_o = dg_reg;
  assign led_green_o = ready;
  // Yellow off on failure since mode clears there
  assign led_yellow_o = yel_mode_reg && (!yel_flash_reg || yph_reg);
  // Steady red for internal failure, coded flashes otherwise
  // A group cut short by a cleared fault goes dark at once
  assign led_red_o = (shown_code == CODE_INTERNAL) ||
                     (rst_state_reg == RED_ON && shown_code != CODE_NONE);

endmodule : ilk_diag

// [tb/ilk_diag_assertions.sv]
// Port checker for the interlock diagnostic controller.
// Assumes it is bound onto ilk_diag and sees only that module's ports.
`timescale 1ns/10ps
module ilk_diag_chk
  import ilk_pkg::*;
#(
  parameter int unsigned SHUTDOWN_TICKS_P = SHUTDOWN_TICKS,  // Warning delay, ticks
  parameter int unsigned TICK_CYC_P = TICK_CYC               // Clocks per tick
) (
  // Clock, reset and bus handshake
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Sensing and fault levels
  input wire logic guard_closed_i,
  input wire logic actuator_in_i,
  input wire logic lock_target_i,
  input wire logic fault_temp_i,
  input wire logic fault_combo_i,
  input wire logic fault_internal_i,
  // Outputs and indicators
  input wire logic guard_safety_out_a_o,
  input wire logic guard_safety_out_b_o,
  input wire logic lock_safety_out_a_o,
  input wire logic lock_safety_out_b_o,
  input wire logic diag_out_o,
  input wire logic led_yellow_o,
  input wire logic led_red_o
);
  // ------
  // Warning age
  // ------
  // Margin covers tick phase and sync stages, so a slow but legal expiry passes
  localparam int unsigned LIM = SHUTDOWN_TICKS_P * TICK_CYC_P + TICK_CYC_P + 8;
  logic [31:0] age_reg;   // Cycles the temperature warning has stood
  logic [31:0] age_next;  // Next age, saturates at the limit
  // Next age
  always_comb begin
    age_next = age_reg;
    if (!fault_temp_i) begin
      age_next = '0;
    end else if (age_reg != LIM) begin
      age_next = age_reg + 32'h1;
    end
  end
  // Age register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      age_reg <= '0;
    end else begin
      age_reg <= age_next;
    end
  end
  // ------
  // Properties
  // ------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_latency: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
    else $error("ack without request");
  chk_red_steady: assert property (fault_internal_i [*6] |-> led_red_o && !guard_safety_out_a_o)
    else $error("internal fault not steady red with outputs off");
  chk_fail_outs: assert property (fault_combo_i [*6] |-> !guard_safety_out_a_o &&
      !guard_safety_out_b_o && lock_safety_out_a_o && !lock_safety_out_b_o && !led_yellow_o)
    else $error("failure output pattern wrong");
  chk_diag_cause: assert property (diag_out_o |-> $past(guard_closed_i, 3) &&
      $past(actuator_in_i, 3) && !$past(fault_temp_i, 3))
    else $error("diagnostic high without its conditions");
  chk_warn_diag: assert property (fault_temp_i [*5] |-> !diag_out_o)
    else $error("diagnostic high during warning");
  chk_lock_need: assert property ((lock_safety_out_a_o && guard_safety_out_a_o) |->
      $past(actuator_in_i, 3) && $past(lock_target_i, 3))
    else $error("lock output on without actuator and target");
  chk_lock_pair: assert property (lock_safety_out_a_o ^ lock_safety_out_b_o)
    else $error("lock outputs not complementary");
  chk_warn_expire: assert property ((age_reg == LIM) |-> !guard_safety_out_a_o)
    else $error("warning did not turn into failure");
endmodule : ilk_diag_chk

bind ilk_diag ilk_diag_chk #(.SHUTDOWN_TICKS_P(SHUTDOWN_TICKS_P), .TICK_CYC_P(TICK_CYC_P)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_ack_o(wb_ack_o), .guard_closed_i(guard_closed_i), .actuator_in_i(actuator_in_i),
  .lock_target_i(lock_target_i), .fault_temp_i(fault_temp_i), .fault_combo_i(fault_combo_i),
  .fault_internal_i(fault_internal_i), .guard_safety_out_a_o(guard_safety_out_a_o),
  .guard_safety_out_b_o(guard_safety_out_b_o), .lock_safety_out_a_o(lock_safety_out_a_o),
  .lock_safety_out_b_o(lock_safety_out_b_o), .diag_out_o(diag_out_o),
  .led_yellow_o(led_yellow_o), .led_red_o(led_red_o));

// [tb/ilk_plc_model.sv]
// Model of the safety controller input stage reading the interlock outputs.
// Assumes the bench clock; outputs a run permission for the machine.
`timescale 1ns/10ps
module ilk_plc_model (
  // Clock
  input wire logic clk_i,
  // Interlock outputs as seen by the controller
  input wire logic ga_i,
  input wire logic gb_i,
  input wire logic la_i,
  input wire logic lb_i,
  // Machine run permission
  output logic run_ok_o
);
  logic run_reg;   // Registered permission, as a real input stage filters
  logic run_next;  // Next permission
  // Restart only with both guard paths and the lock chain locked
  always_comb begin
    run_next = ga_i & gb_i & la_i & ~lb_i;
  end
  // Permission register
  always_ff @(posedge clk_i) begin
    run_reg <= run_next;
  end
  assign run_ok_o = run_reg;
endmodule : ilk_plc_model

// [tb/ilk_diag_tb_top.sv]
// Bench for the interlock controller: bus tasks, sensor states, fault codes.
// Assumes ilk_pkg, the checker bind and the controller model are compiled first.
`timescale 1ns/10ps
module ilk_diag_tb_top;
  import ilk_pkg::*;
  localparam int unsigned TC = 4;   // Clocks per tick, shortened
  localparam int unsigned ST = 20;  // Warning delay in ticks, shortened
  logic clk_i, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic wb_ack_o, guard_closed_i = 1'b0, actuator_in_i = 1'b0, actuator_marginal_i = 1'b0;
  logic lock_target_i = 1'b0, run_ok, led_green_o, led_yellow_o, led_red_o;
  logic guard_safety_out_a_o, guard_safety_out_b_o, lock_safety_out_a_o;
  logic lock_safety_out_b_o, diag_out_o;
  logic [6:0] flt = 7'h00;  // Fault levels, bit 0 output A up to bit 6 internal
  logic [2:0] wc [5] = '{CODE_OUT_A, CODE_OUT_B, CODE_CROSS, CODE_CROSS, CODE_TEMP};
  logic [6:0] wv [5] = '{7'h01, 7'h02, 7'h04, 7'h03, 7'h08};
  logic [2:0] ic [3] = '{CODE_ACT, CODE_COMBO, CODE_INTERNAL};
  int n, errors = 0, comparisons = 0;
  wire logic [4:0] ov = {diag_out_o, lock_safety_out_b_o, lock_safety_out_a_o,
    guard_safety_out_b_o, guard_safety_out_a_o};
  ilk_diag #(.SHUTDOWN_TICKS_P(ST), .TICK_CYC_P(TC)) DUT (.clk_i, .rst_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .guard_closed_i, .actuator_in_i, .actuator_marginal_i, .lock_target_i,
    .fault_out_a_i(flt[0]), .fault_out_b_i(flt[1]), .fault_cross_i(flt[2]),
    .fault_temp_i(flt[3]), .fault_actuator_i(flt[4]), .fault_combo_i(flt[5]),
    .fault_internal_i(flt[6]), .guard_safety_out_a_o, .guard_safety_out_b_o,
    .lock_safety_out_a_o, .lock_safety_out_b_o, .diag_out_o, .led_green_o,
    .led_yellow_o, .led_red_o);
  ilk_plc_model u_plc (.clk_i, .ga_i(guard_safety_out_a_o), .gb_i(guard_safety_out_b_o),
    .la_i(lock_safety_out_a_o), .lb_i(lock_safety_out_b_o), .run_ok_o(run_ok));
  // ------
  // Tasks
  // ------
  // Value comparison
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  // Classic Wishbone cycle; waits for ack, no fixed latency assumed
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : wb
  // Sensors {guard, actuator, marginal, target}, then settle
  task automatic sens(input logic [3:0] v);
    @(posedge clk_i);
    {guard_closed_i, actuator_in_i, actuator_marginal_i, lock_target_i} <= v;
    repeat (8) @(posedge clk_i);
  endtask : sens
  // Fault levels, then settle
  task automatic fset(input logic [6:0] v);
    @(posedge clk_i);
    flt <= v;
    repeat (8) @(posedge clk_i);
  endtask : fset
  // Cycles between two yellow changes; 3000 means steady
  task automatic yel;
    logic p;
    p = led_yellow_o;
    n = 0;
    while (led_yellow_o === p && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    p = led_yellow_o;
    n = 0;
    while (led_yellow_o === p && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
  endtask : yel
  // Red pulses between two long dark gaps; short gaps belong to one group
  task automatic red_group;
    int g;
    logic p;
    g = 0;
    p = 1'b0;
    while (g < 2400) begin
      @(posedge clk_i);
      g = led_red_o ? 0 : g + 1;
    end
    n = 0;
    while (!(g >= 2400 && n > 0)) begin
      @(posedge clk_i);
      if (led_red_o && !p) n++;
      p = led_red_o;
      g = led_red_o ? 0 : g + 1;
    end
  endtask : red_group
  // Verdict and end of run
  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up
  // ------
  // Clock, watchdog, tests
  // ------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Tests need about 36k cycles
  initial begin
    repeat (100000) @(posedge clk_i);
    errors++;
    wrap_up;
  end
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    chk("outs", 5'h08, ov);
    chk("green", 1'b1, led_green_o);
    wb(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl", 32'h1, q);
    wb(1'b0, 4'h2, 32'h0);
    chk("unmapped", 32'h0, q);
    $display("reset test done");
    sens(4'h8);
    chk("outs", 5'h0B, ov);
    yel;
    chk("yellow half", YEL_HALF_TICKS * TC, n);
    sens(4'hC);
    chk("outs", 5'h1B, ov);
    yel;
    chk("yellow half", YEL_HALF_TICKS * TC, n);
    chk("run", 1'b0, run_ok);
    wb(1'b1, ADDR_CTRL, 32'h3);
    repeat (4) @(posedge clk_i);
    chk("outs", 5'h1B, ov);
    yel;
    chk("yellow half", YEL_HALF_TICKS * TC, n);
    sens(4'hD);
    chk("outs", 5'h17, ov);
    wb(1'b0, ADDR_OUTS, 32'h0);
    chk("outs reg", 32'hAF, q);
    chk("run", 1'b1, run_ok);
    yel;
    chk("yellow steady", 32'h1771, {n[30:0], led_yellow_o});
    sens(4'hF);
    yel;
    chk("yellow half", YEL_HALF_TICKS * TC, n);
    sens(4'hD);
    $display("sensor test done");
    for (int i = 0; i < 5; i++) begin
      fset(wv[i]);
      chk("outs", 5'h07, ov);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk("code", wc[i], q[11:9]);
      if (i == 2) begin
        red_group;
        chk("pulses", wc[i], n);
      end
      fset(7'h00);
      if (i == 2) begin
        sens(4'h0);
        sens(4'hD);
      end
      chk("outs", 5'h17, ov);
      chk("red", 1'b0, led_red_o);
    end
    $display("warning test done");
    fset(7'h08);
    repeat (40) @(posedge clk_i);
    chk("outs", 5'h07, ov);
    repeat (120) @(posedge clk_i);
    chk("outs", 5'h04, ov);
    chk("yellow", 1'b0, led_yellow_o);
    wb(1'b0, ADDR_TIMER, 32'h0);
    chk("timer", ST, q);
    fset(7'h00);
    chk("outs", 5'h04, ov);
    sens(4'h0);
    sens(4'hD);
    chk("outs", 5'h17, ov);
    $display("expiry test done");
    for (int i = 0; i < 3; i++) begin
      fset(7'h10 << i);
      chk("outs", 5'h04, ov);
      wb(1'b0, ADDR_STATUS, 32'h0);
      chk("code", ic[i], q[11:9]);
      if (i == 1) begin
        red_group;
        chk("pulses", ic[i], n);
      end
      if (i == 2) begin
        repeat (1000) @(posedge clk_i);
        chk("red steady", 1'b1, led_red_o);
      end
      fset(7'h00);
      sens(4'h0);
      sens(4'hD);
      chk("outs", 5'h17, ov);
    end
    $display("failure test done");
    wb(1'b1, ADDR_CTRL, 32'h0);
    repeat (4) @(posedge clk_i);
    chk("green", 1'b0, led_green_o);
    wb(1'b1, ADDR_CTRL, 32'h3);
    repeat (4) @(posedge clk_i);
    chk("green", 1'b1, led_green_o);
    $display("ready test done");
    wrap_up;
  end
endmodule : ilk_diag_tb_top
